// *** rtl/fsr_pkg.sv ***
// package: constants, register map and status layout for the flash status poller
// Behaviour
// - host masks reserved bit 0 out of every polled status value; the raw register (FSR_RAW_OFS) returns it unmasked
// - host ignores bits 6..0 while bit 7 reads busy
// - bits 5 and 4 both set mean an improper command sequence
// - host issues clear-status if supply-low bit is ever seen set; the host only reports it in status bits 9..8, clearing on ctrl bit 1
// - host reads lock codes in identifier mode for true lock state; the host sends only read-status, clear-status and read-array commands
// - host detects completion via ready/busy output or status bit 7
// - host writes ffff after the last operation to return to array read
// - host issues clear-status after any error before retry or recovery; the host still accepts a new poll while the error flags are set
package fsr_pkg;
	// apb register offsets
	localparam logic [7:0] FSR_CTRL_OFS = 8'h00;
	localparam logic [7:0] FSR_STAT_OFS = 8'h04;
	localparam logic [7:0] FSR_WORD_OFS = 8'h08;
	localparam logic [7:0] FSR_RAW_OFS = 8'h0c;
	localparam logic [7:0] FSR_ADDR_OFS = 8'h10;
	localparam logic [31:0] FSR_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FSR_ADDR_RST = 32'h0000_0000;
	// ctrl field positions
	localparam int FSR_CTRL_GO = 0;
	localparam int FSR_CTRL_CLR = 1;
	localparam int FSR_CTRL_ARR = 2;
	localparam int FSR_CTRL_RSP = 3;
	// status bit positions within a byte
	localparam int FSR_READY_BIT = 7;
	localparam int FSR_ESUSP_BIT = 6;
	localparam int FSR_EERR_BIT = 5;
	localparam int FSR_PERR_BIT = 4;
	localparam int FSR_VLOW_BIT = 3;
	localparam int FSR_PSUSP_BIT = 2;
	localparam int FSR_PROT_BIT = 1;
	localparam int FSR_RSVD_BIT = 0;
	localparam logic [7:0] FSR_RSVD_MASK = 8'hfe;
	// device commands (byte replicated on both lanes)
	localparam logic [15:0] FSR_CMD_READ_STATUS = 16'h7070;
	localparam logic [15:0] FSR_CMD_CLEAR_STATUS = 16'h5050;
	localparam logic [15:0] FSR_CMD_READ_ARRAY = 16'hffff;
	// bus timing: 25 ns clock, 80 ns write pulse, 150 ns access, 75 ns float
	localparam int FSR_CLK_NS = 25;
	localparam int FSR_T_ACCESS_NS = 150;
	localparam int FSR_T_WPULSE_NS = 80;
	localparam int FSR_T_RECOV_NS = 75;
	localparam int FSR_ACC_CYC = (FSR_T_ACCESS_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
	localparam int FSR_WP_CYC = (FSR_T_WPULSE_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
	localparam int FSR_REC_CYC = (FSR_T_RECOV_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
	localparam int FSR_CNT_W = 4;
	localparam logic [FSR_CNT_W-1:0] FSR_ACC_CNT = FSR_CNT_W'(FSR_ACC_CYC);
	localparam logic [FSR_CNT_W-1:0] FSR_WP_CNT = FSR_CNT_W'(FSR_WP_CYC);
	localparam logic [FSR_CNT_W-1:0] FSR_REC_CNT = FSR_CNT_W'(FSR_REC_CYC);
	typedef enum {
		FSR_IDLE, FSR_WR_LOW, FSR_WR_REC, FSR_RD_LOW, FSR_RD_REC, FSR_DECIDE
	} fsr_state_t;
	typedef enum {FSR_OP_NONE, FSR_OP_POLL, FSR_OP_CLR, FSR_OP_ARR} fsr_op_t;
endpackage

// *** rtl/fsr_timer.sv ***
// down counter giving a one-cycle done pulse for bus phase timing
`timescale 1ns/10ps
module fsr_timer
	import fsr_pkg::*;
#(
	parameter int W = FSR_CNT_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] cnt_reg;
	logic run_reg;
	wire last = run_reg && (cnt_reg == W'(1));
	assign done = last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else if (load) begin
			cnt_reg <= count;
			run_reg <= 1'b1;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg - W'(1);
			run_reg <= !last;
		end
	end
endmodule

// *** rtl/fsr_decode.sv ***
// splits a 16-bit status word into per-lane masked flags and error summaries
`timescale 1ns/10ps
module fsr_decode
	import fsr_pkg::*;
(
	// raw word from the card
	input wire logic [15:0] raw,
	// per-lane results, lane 1 is the odd device
	output logic [15:0] masked,
	output logic [1:0] ready,
	output logic [1:0] err,
	output logic [1:0] seq_err,
	output logic [1:0] vlow
);
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_lane
			wire [7:0] b = raw[8*i +: 8];
			// reserved bit dropped; bits 6..0 ignored while busy
			assign masked[8*i +: 8] = b[FSR_READY_BIT] ? (b & FSR_RSVD_MASK) : 8'h00;
			assign ready[i] = b[FSR_READY_BIT];
			assign err[i] = b[FSR_READY_BIT] && (b[FSR_EERR_BIT] || b[FSR_PERR_BIT]
				|| b[FSR_VLOW_BIT] || b[FSR_PROT_BIT]);
			assign seq_err[i] = b[FSR_READY_BIT] && b[FSR_EERR_BIT] && b[FSR_PERR_BIT];
			assign vlow[i] = b[FSR_READY_BIT] && b[FSR_VLOW_BIT];
		end
	endgenerate
endmodule

// *** rtl/fsr_host.sv ***
// apb-controlled host that polls, clears and releases the flash card status
`timescale 1ns/10ps
module fsr_host
	import fsr_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// card bus
	output logic [23:0] card_addr,
	output logic card_ce_n,
	output logic card_oe_n,
	output logic card_we_n,
	output logic [15:0] card_dq_out,
	output logic card_dq_oe,
	input wire logic [15:0] card_dq_in,
	input wire logic ready_busy_output,
	output logic reset_powerdown_input
);
	logic [31:0] addr_reg;
	logic [15:0] raw_reg;
	logic busy_reg, done_reg, ready_seen_reg;
	logic rsp_reg;
	fsr_state_t state_reg, state_next;
	fsr_op_t op_reg;
	logic [15:0] dq_reg;
	logic ce_reg, oe_reg, we_reg, dq_oe_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic tload;
	logic [FSR_CNT_W-1:0] tcount;
	logic tdone;
	logic [15:0] masked;
	logic [1:0] lane_rdy, lane_err, lane_seq, lane_vlow;
	fsr_timer #(.W(FSR_CNT_W)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(tload),
		.count(tcount),
		.done(tdone)
	);
	fsr_decode u_dec (
		.raw(raw_reg),
		.masked(masked),
		.ready(lane_rdy),
		.err(lane_err),
		.seq_err(lane_seq),
		.vlow(lane_vlow)
	);
	// apb decode: answer in the second access cycle, one wait state
	wire acc = psel && penable && !pready_reg;
	wire wr = acc && pwrite;
	wire sel_ctrl = paddr == FSR_CTRL_OFS;
	wire sel_stat = paddr == FSR_STAT_OFS;
	wire sel_word = paddr == FSR_WORD_OFS;
	wire sel_raw = paddr == FSR_RAW_OFS;
	wire sel_addr = paddr == FSR_ADDR_OFS;
	wire mapped = sel_ctrl || sel_stat || sel_word || sel_raw || sel_addr;
	wire go = wr && sel_ctrl && !busy_reg;
	wire go_poll = go && pwdata[FSR_CTRL_GO];
	wire go_clr = go && pwdata[FSR_CTRL_CLR];
	wire go_arr = go && pwdata[FSR_CTRL_ARR];
	wire any_err = |lane_err;
	wire all_rdy = &lane_rdy;
	wire [31:0] stat_val = {22'h0, lane_vlow, lane_seq, any_err, all_rdy,
		ready_busy_output, busy_reg, done_reg, ready_seen_reg};
	wire [31:0] rd_mux = sel_ctrl ? {28'h0, rsp_reg, 3'h0} :
		sel_stat ? stat_val :
		sel_word ? {16'h0, masked} :
		sel_raw ? {16'h0, raw_reg} :
		sel_addr ? addr_reg : 32'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= acc;
			pslverr_reg <= acc && (!mapped || (pwrite && sel_ctrl && busy_reg));
			prdata_reg <= (acc && !pwrite) ? rd_mux : 32'h0;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= FSR_ADDR_RST;
			rsp_reg <= FSR_CTRL_RST[FSR_CTRL_RSP];
		end else if (wr && sel_addr) begin
			addr_reg <= pwdata;
		end else if (go) begin
			// a refused ctrl write must leave the pin level alone too
			rsp_reg <= pwdata[FSR_CTRL_RSP];
		end
	end
	// op priority: clear status first, then release to array read, poll last
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg <= FSR_OP_NONE;
		end else if (go_clr) begin
			op_reg <= FSR_OP_CLR;
		end else if (go_arr) begin
			op_reg <= FSR_OP_ARR;
		end else if (go_poll) begin
			op_reg <= FSR_OP_POLL;
		end
	end
	wire start = go_clr || go_arr || go_poll;
	wire [15:0] cmd_word = (op_reg == FSR_OP_CLR) ? FSR_CMD_CLEAR_STATUS :
		(op_reg == FSR_OP_ARR) ? FSR_CMD_READ_ARRAY : FSR_CMD_READ_STATUS;
	// poll finishes on the ready flag of both devices, not on a fixed time
	wire poll_again = (op_reg == FSR_OP_POLL) && !all_rdy;
	always_comb begin
		state_next = state_reg;
		tload = 1'b0;
		tcount = FSR_WP_CNT;
		case (state_reg)
			FSR_IDLE: begin
				if (start) begin
					state_next = FSR_WR_LOW;
					tload = 1'b1;
				end
			end
			FSR_WR_LOW: begin
				if (tdone) begin
					state_next = FSR_WR_REC;
					tload = 1'b1;
					tcount = FSR_REC_CNT;
				end
			end
			FSR_WR_REC: begin
				if (tdone) begin
					state_next = (op_reg == FSR_OP_POLL) ? FSR_RD_LOW : FSR_IDLE;
					tload = op_reg == FSR_OP_POLL;
					tcount = FSR_ACC_CNT;
				end
			end
			FSR_RD_LOW: begin
				if (tdone) begin
					state_next = FSR_RD_REC;
					tload = 1'b1;
					tcount = FSR_REC_CNT;
				end
			end
			FSR_RD_REC: begin
				if (tdone) begin
					state_next = FSR_DECIDE;
				end
			end
			FSR_DECIDE: begin
				// status mode persists, so repeat reads need no new command
				state_next = poll_again ? FSR_RD_LOW : FSR_IDLE;
				tload = poll_again;
				tcount = FSR_ACC_CNT;
			end
			default: state_next = FSR_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= FSR_IDLE;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			ready_seen_reg <= 1'b0;
			raw_reg <= 16'h0;
		end else begin
			state_reg <= state_next;
			busy_reg <= state_next != FSR_IDLE;
			if (start) begin
				done_reg <= 1'b0;
			end else if (state_reg != FSR_IDLE && state_next == FSR_IDLE) begin
				done_reg <= 1'b1;
			end
			if (state_reg == FSR_RD_LOW && tdone) begin
				raw_reg <= card_dq_in;
			end
			if (state_reg == FSR_DECIDE) begin
				ready_seen_reg <= all_rdy;
			end else if (start) begin
				ready_seen_reg <= 1'b0;
			end
		end
	end
	// pins are registered; strobes low only inside their timed phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_reg <= 1'b1;
			oe_reg <= 1'b1;
			we_reg <= 1'b1;
			dq_oe_reg <= 1'b0;
			dq_reg <= 16'h0;
		end else begin
			ce_reg <= !(state_next == FSR_WR_LOW || state_next == FSR_RD_LOW);
			we_reg <= state_next != FSR_WR_LOW;
			oe_reg <= state_next != FSR_RD_LOW;
			dq_oe_reg <= state_next == FSR_WR_LOW || state_next == FSR_WR_REC;
			dq_reg <= cmd_word;
		end
	end
	assign card_ce_n = ce_reg;
	assign card_oe_n = oe_reg;
	assign card_we_n = we_reg;
	assign card_dq_oe = dq_oe_reg;
	assign card_dq_out = dq_reg;
	assign card_addr = addr_reg[23:0];
	// lock state is only valid after an operation; the pin follows ctrl bit 3 and is held low from reset
	assign reset_powerdown_input = rsp_reg;
endmodule

// *** testbench/fsr_card.sv ***
// card model: two byte-wide devices answering status and command writes
`timescale 1ns/10ps
module fsr_card
	import fsr_pkg::*;
(
	// card strobes
	input wire logic card_ce_n,
	input wire logic card_oe_n,
	input wire logic card_we_n,
	input wire logic [15:0] card_dq_out,
	input wire logic card_dq_oe,
	input wire logic reset_powerdown_input,
	// answers
	output logic [15:0] card_dq_in,
	output logic ready_busy_output
);
	logic [15:0] stat_reg = 16'h8080;
	logic [15:0] cmd_reg = 16'h0000;
	logic [15:0] q = 16'h0000;
	logic arr_mode = 1'b0;
	int busy_n = 0;
	assign ready_busy_output = (busy_n == 0);
	// released bus shows the inverse, so a late sample never looks right
	assign card_dq_in = (card_oe_n || card_ce_n) ? ~q : q;
	// powered-down card ignores commands
	always @(posedge card_we_n) begin
		if (card_dq_oe && reset_powerdown_input) begin
			cmd_reg = card_dq_out;
			arr_mode = (card_dq_out == FSR_CMD_READ_ARRAY);
			if (card_dq_out == FSR_CMD_CLEAR_STATUS)
				stat_reg = stat_reg & 16'hc5c5;
		end
	end
	always @(negedge card_oe_n) begin
		if (arr_mode)
			q = 16'h5aa5;
		else if (busy_n > 0)
			q = 16'h7f7f;
		else
			q = stat_reg;
	end
	always @(posedge card_oe_n) begin
		if (busy_n > 0)
			busy_n--;
	end
endmodule

// *** testbench/fsr_host_chk.sv ***
// checker: apb timing, polled word masking and card strobe shapes
`timescale 1ns/10ps
module fsr_host_chk
	import fsr_pkg::*;
(
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// card side
	input wire logic card_oe_n,
	input wire logic card_we_n,
	input wire logic card_dq_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire word_rd = psel && penable && pready && !pwrite && paddr == FSR_WORD_OFS;
	property p_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_wait: assert property (p_wait) else $error("pready late");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one) else $error("pready too long");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("stray pslverr");
	property p_mask;
		word_rd |-> !prdata[8] && !prdata[0];
	endproperty
	a_mask: assert property (p_mask) else $error("reserved bit shown");
	property p_busy;
		word_rd |-> (prdata[15] || prdata[14:8] == 0) && (prdata[7] || prdata[6:0] == 0);
	endproperty
	a_busy: assert property (p_busy) else $error("busy lane not zero");
	property p_strb;
		!card_oe_n |-> card_we_n && !card_dq_oe;
	endproperty
	a_strb: assert property (p_strb) else $error("read overlaps drive");
	property p_wpul;
		$fell(card_we_n) |-> (!card_we_n) [*4] ##1 card_we_n;
	endproperty
	a_wpul: assert property (p_wpul) else $error("write pulse length");
	property p_rpul;
		$fell(card_oe_n) |-> (!card_oe_n) [*6] ##1 card_oe_n;
	endproperty
	a_rpul: assert property (p_rpul) else $error("read pulse length");
endmodule

// *** testbench/flash_status_reporting_tb.sv ***
// testbench: apb-driven status polling against the card model
`timescale 1ns/10ps
module flash_status_reporting_tb
	import fsr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, card_ce_n, card_oe_n, card_we_n, card_dq_oe;
	logic ready_busy_output, reset_powerdown_input;
	logic [23:0] card_addr;
	logic [15:0] card_dq_out, card_dq_in;
	int fail_count = 0, n_checks = 0;
	fsr_host i_fsr_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .card_addr, .card_ce_n, .card_oe_n, .card_we_n,
		.card_dq_out, .card_dq_oe, .card_dq_in, .ready_busy_output, .reset_powerdown_input);
	fsr_card i_fsr_card (.card_ce_n, .card_oe_n, .card_we_n, .card_dq_out, .card_dq_oe,
		.reset_powerdown_input, .card_dq_in, .ready_busy_output);
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one transfer, then an idle edge so no signal is driven twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			fail_count++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, FSR_STAT_OFS, 32'h0);
			n++;
		end while (rd[2] !== 1'b0 && n < 100);
		if (rd[2] !== 1'b0) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic run(input logic [31:0] ctrl);
		apb(1'b1, FSR_CTRL_OFS, ctrl);
		chk(er, 1'b0);
		wait_idle();
	endtask
	task automatic t_regs;
		apb(1'b0, FSR_CTRL_OFS, 32'h0);
		chk(rd, FSR_CTRL_RST);
		chk(reset_powerdown_input, 1'b0);
		apb(1'b0, FSR_ADDR_OFS, 32'h0);
		chk(rd, FSR_ADDR_RST);
		apb(1'b1, FSR_ADDR_OFS, 32'h00ab_cd12);
		apb(1'b0, FSR_ADDR_OFS, 32'h0);
		chk(rd, 32'h00ab_cd12);
		chk(card_addr, 24'hab_cd12);
		apb(1'b0, 8'h3c, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("regs done");
	endtask
	task automatic t_status;
		i_fsr_card.stat_reg = 16'hb289;
		run(32'h9);
		chk(reset_powerdown_input, 1'b1);
		chk(rd[9:0], 10'h1bb);
		apb(1'b0, FSR_WORD_OFS, 32'h0);
		chk(rd, 32'hb288);
		apb(1'b0, FSR_RAW_OFS, 32'h0);
		chk(rd, 32'hb289);
		chk(i_fsr_card.cmd_reg, FSR_CMD_READ_STATUS);
		$display("status done");
	endtask
	task automatic t_busy;
		i_fsr_card.stat_reg = 16'hc4c4;
		i_fsr_card.busy_n = 3;
		apb(1'b1, FSR_CTRL_OFS, 32'h9);
		apb(1'b0, FSR_STAT_OFS, 32'h0);
		chk(rd[2], 1'b1);
		chk(rd[3], 1'b0);
		apb(1'b1, FSR_CTRL_OFS, 32'h2);
		chk(er, 1'b1);
		chk(reset_powerdown_input, 1'b1);
		wait_idle();
		chk(rd[5:0], 6'h1b);
		chk(i_fsr_card.cmd_reg, FSR_CMD_READ_STATUS);
		apb(1'b0, FSR_WORD_OFS, 32'h0);
		chk(rd, 32'hc4c4);
		$display("busy done");
	endtask
	task automatic t_clear;
		i_fsr_card.stat_reg = 16'hb2b2;
		run(32'h9);
		chk(rd[5], 1'b1);
		run(32'hb);
		chk(i_fsr_card.cmd_reg, FSR_CMD_CLEAR_STATUS);
		run(32'h9);
		apb(1'b0, FSR_WORD_OFS, 32'h0);
		chk(rd, 32'h8080);
		run(32'hc);
		chk(i_fsr_card.cmd_reg, FSR_CMD_READ_ARRAY);
		$display("clear done");
	endtask
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_status();
		t_busy();
		t_clear();
		stop_test();
	end
endmodule
bind fsr_host fsr_host_chk i_fsr_host_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .card_oe_n, .card_we_n, .card_dq_oe);
